// ---- hpc_pkg.sv ----
// shared constants, states and carriers of the hot-plug slot register bank
package hpc_pkg;

    // command byte values that select a register
    localparam logic [7:0] CMD_SLOT_B_CTRL  = 8'h03;
    localparam logic [7:0] CMD_SLOT_A_STAT  = 8'h04;

    // power-up values
    localparam logic [7:0] SLOT_B_CTRL_RST  = 8'h00;
    localparam logic [7:0] SLOT_A_STAT_RST  = 8'h00;
    localparam logic [7:0] CMD_PTR_RST      = 8'h00;

    // upper four bits of the 7-bit bus address, straps fill the rest
    localparam logic [3:0] SMB_ADDR_HIGH    = 4'h8;

    // slot_b_power_control field positions
    localparam int B_AUX_EN_BIT     = 0;
    localparam int B_MAIN_EN_BIT    = 1;
    localparam int B_FORCE_GATE_BIT = 2;
    localparam int B_MAIN_GOOD_BIT  = 6;
    localparam int B_AUX_GOOD_BIT   = 7;

    // slot_a_power_status field positions
    localparam int A_3V3_OC_BIT     = 0;
    localparam int A_12V_OC_BIT     = 2;
    localparam int A_AUX_OC_BIT     = 4;
    localparam int A_AUX_STATE_BIT  = 5;
    localparam int A_MAIN_STATE_BIT = 6;
    localparam int A_FAULT_BIT      = 7;

    // overcurrent flags: index 0 = 3.3V, 1 = +12V, 2 = aux
    localparam int NUM_OC           = 3;
    localparam int OC_3V3           = 0;
    localparam int OC_12V           = 1;
    localparam int OC_AUX           = 2;

    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        SMB_IDLE      = 3'b000,
        SMB_ADDR      = 3'b001,
        SMB_CMD       = 3'b010,
        SMB_WDATA     = 3'b011,
        SMB_ACK_SETUP = 3'b100,
        SMB_ACK       = 3'b101,
        SMB_RDATA     = 3'b110,
        SMB_MACK      = 3'b111
    } hpc_smb_state_e;

    typedef struct packed {
        logic aux_good;     // aux output above lockout threshold
        logic main_good;    // all main outputs above lockout threshold
        logic force_on_n;   // force-on pin, active low
    } hpc_slot_b_in_s;

    typedef struct packed {
        logic       main_state;     // main outputs actually on
        logic       aux_state;      // aux output actually on
        logic       main_on_in;     // main-on input pin
        logic       aux_enable_in;  // aux-enable input pin
        logic       smi_ctrl;       // power paths run from the management interface
        logic [2:0] trip;           // breaker trip per supply
    } hpc_slot_a_in_s;

    typedef struct packed {
        logic force_gate;   // 1 = ignore force-on pin
        logic main_enable;
        logic aux_enable;
    } hpc_slot_b_ctrl_s;

endpackage

// ---- hpc_slot_regs.sv ----
// bus slave, slot B control register and slot A status register
`timescale 1ns/100ps
module hpc_slot_regs
    import hpc_pkg::*;
(
    input  wire logic           core_clk,            // 10 MHz clock
    input  wire logic           rst_b,               // async reset, active low
    input  wire logic           smb_scl,             // bus clock
    input  wire logic           smb_sda_in,          // bus data level
    output logic                smb_sda_out,         // bus data drive value
    output logic                smb_sda_oe,          // bus data pulled low
    output logic                alert_n_out,         // interrupt drive value
    output logic                alert_n_oe,          // interrupt pulled low
    input  wire logic           addr_strap_2,        // address strap bit 2
    input  wire logic           addr_strap_1,        // address strap bit 1
    input  wire logic           addr_strap_0,        // address strap bit 0
    input  wire hpc_slot_b_in_s slot_b_in,           // slot B sense inputs
    input  wire hpc_slot_a_in_s slot_a_in,           // slot A sense inputs
    output logic                slot_b_aux_enable,   // slot B aux switch
    output logic                slot_b_main_enable,  // slot B main switch
    output logic                slot_b_power_good_n_out, // power-good drive value
    output logic                slot_b_power_good_n_oe,  // power-good pulled low
    output logic                slot_a_fault_n_out,  // fault drive value
    output logic                slot_a_fault_n_oe    // fault pulled low
);

    // reset release
    logic rst_meta_b;
    logic rst_sync_b;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // strap capture, once after reset release
    logic       strap_done;
    logic [2:0] dev_addr_low;
    logic       next_strap_done;
    logic [2:0] next_dev_addr_low;
    always_comb begin
        next_strap_done   = 1'b1;
        next_dev_addr_low = dev_addr_low;
        if (!strap_done) begin
            next_dev_addr_low = {addr_strap_2, addr_strap_1, addr_strap_0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            strap_done   <= 1'b0;
            dev_addr_low <= 3'h0;
        end else begin
            strap_done   <= next_strap_done;
            dev_addr_low <= next_dev_addr_low;
        end
    end

    // bus line sampling; pins are synchronous, so one stage plus history
    logic scl_q;
    logic sda_q;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q <= smb_scl;
            sda_q <= smb_sda_in;
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_q & ~scl_d;
    assign scl_fall  = ~scl_q & scl_d;
    assign bus_start = scl_q & scl_d & sda_d & ~sda_q;
    assign bus_stop  = scl_q & scl_d & ~sda_d & sda_q;
    // register state
    hpc_slot_b_ctrl_s   ctrl_b;
    hpc_slot_b_ctrl_s   next_ctrl_b;
    logic [NUM_OC-1:0]  oc_flag;
    logic [NUM_OC-1:0]  oc_clr;
    logic               main_pend;
    logic               aux_pend;
    logic               next_main_pend;
    logic               next_aux_pend;
    logic               fault_active;
    logic [7:0]         ctrl_b_rd;
    logic [7:0]         stat_a_rd;
    logic [7:0]         rd_data;
    // bus engine state
    hpc_smb_state_e state;
    hpc_smb_state_e next_state;
    hpc_smb_state_e ack_next;
    hpc_smb_state_e next_ack_next;
    logic [7:0]     shreg;
    logic [7:0]     next_shreg;
    logic [2:0]     bitcnt;
    logic [2:0]     next_bitcnt;
    logic           ack_en;
    logic           next_ack_en;
    logic [7:0]     cmd_ptr;
    logic [7:0]     next_cmd_ptr;
    logic           sda_oe_q;
    logic           next_sda_oe;
    logic           wr_en;
    logic [7:0]     wr_data;
    logic [7:0]     rx_byte;
    assign rx_byte = {shreg[6:0], sda_q};
    always_comb begin
        next_state    = state;
        next_ack_next = ack_next;
        next_shreg    = shreg;
        next_bitcnt   = bitcnt;
        next_ack_en   = ack_en;
        next_cmd_ptr  = cmd_ptr;
        wr_en         = 1'b0;
        wr_data       = rx_byte;
        unique case (state)
            SMB_IDLE: begin
            end
            SMB_ADDR, SMB_CMD, SMB_WDATA: begin
                if (scl_rise) begin
                    next_shreg  = rx_byte;
                    next_bitcnt = bitcnt + 3'h1;
                    if (bitcnt == BIT_LAST) begin
                        next_state  = SMB_ACK_SETUP;
                        next_ack_en = 1'b1;
                        if (state == SMB_ADDR) begin
                            if (rx_byte[7:1] != {SMB_ADDR_HIGH, dev_addr_low}) begin
                                next_state = SMB_IDLE;
                            end
                            next_ack_next = rx_byte[0] ? SMB_RDATA : SMB_CMD;
                        end else if (state == SMB_CMD) begin
                            next_cmd_ptr  = rx_byte;
                            next_ack_next = SMB_WDATA;
                        end else begin
                            wr_en         = 1'b1;
                            next_ack_next = SMB_WDATA;
                        end
                    end
                end
            end
            SMB_ACK_SETUP: begin
                // wait for clock low so driving data cannot fake a start or stop
                if (scl_fall) begin
                    next_state = SMB_ACK;
                end
            end
            SMB_ACK: begin
                if (scl_fall) begin
                    next_state  = ack_next;
                    next_bitcnt = 3'h0;
                    if (ack_next == SMB_RDATA) begin
                        next_shreg = rd_data;
                    end
                end
            end
            SMB_RDATA: begin
                if (scl_fall) begin
                    if (bitcnt == BIT_LAST) begin
                        next_state = SMB_MACK;
                    end else begin
                        next_shreg  = {shreg[6:0], 1'b0};
                        next_bitcnt = bitcnt + 3'h1;
                    end
                end
            end
            SMB_MACK: begin
                // a not-acknowledge ends the read; an acknowledge resends
                if (scl_rise && sda_q) begin
                    next_state = SMB_IDLE;
                end else if (scl_fall) begin
                    next_state  = SMB_RDATA;
                    next_shreg  = rd_data;
                    next_bitcnt = 3'h0;
                end
            end
        endcase
        if (bus_start) begin
            next_state  = SMB_ADDR;
            next_bitcnt = 3'h0;
        end else if (bus_stop) begin
            next_state = SMB_IDLE;
        end
        next_sda_oe = ((next_state == SMB_ACK) && next_ack_en) ||
                      ((next_state == SMB_RDATA) && !next_shreg[7]);
    end
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state    <= SMB_IDLE;
            ack_next <= SMB_IDLE;
            shreg    <= 8'h00;
            bitcnt   <= 3'h0;
            ack_en   <= 1'b0;
            cmd_ptr  <= CMD_PTR_RST;
            sda_oe_q <= 1'b0;
        end else begin
            state    <= next_state;
            ack_next <= next_ack_next;
            shreg    <= next_shreg;
            bitcnt   <= next_bitcnt;
            ack_en   <= next_ack_en;
            cmd_ptr  <= next_cmd_ptr;
            sda_oe_q <= next_sda_oe;
        end
    end

    assign smb_sda_out = 1'b0;
    assign smb_sda_oe  = sda_oe_q;
    // slot B control register
    always_comb begin
        next_ctrl_b = ctrl_b;
        if (wr_en && (cmd_ptr == CMD_SLOT_B_CTRL)) begin
            next_ctrl_b.aux_enable  = wr_data[B_AUX_EN_BIT];
            next_ctrl_b.main_enable = wr_data[B_MAIN_EN_BIT];
            next_ctrl_b.force_gate  = wr_data[B_FORCE_GATE_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl_b <= SLOT_B_CTRL_RST[2:0];
        end else begin
            ctrl_b <= next_ctrl_b;
        end
    end

    assign slot_b_aux_enable  = ctrl_b.aux_enable;
    assign slot_b_main_enable = ctrl_b.main_enable;
    // pin pulled low means power good; released is the not-good state
    logic slot_b_good;
    logic force_hit;
    always_comb begin
        force_hit   = ~slot_b_in.force_on_n & ~ctrl_b.force_gate;
        slot_b_good = slot_b_in.aux_good & slot_b_in.main_good & ~force_hit;
    end

    assign slot_b_power_good_n_out = 1'b0;
    assign slot_b_power_good_n_oe  = slot_b_good;

    // overcurrent flags and their write-one clears
    logic [7:0] oc_pos [NUM_OC];
    assign oc_pos[OC_3V3] = 8'(A_3V3_OC_BIT);
    assign oc_pos[OC_12V] = 8'(A_12V_OC_BIT);
    assign oc_pos[OC_AUX] = 8'(A_AUX_OC_BIT);
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OC; gi++) begin : g_oc
            assign oc_clr[gi] = wr_en && (cmd_ptr == CMD_SLOT_A_STAT) &&
                                wr_data[oc_pos[gi][2:0]];
            hpc_sticky_flag u_flag (
                .core_clk   (core_clk),
                .rst_sync_b (rst_sync_b),
                .set        (slot_a_in.trip[gi]),
                .clr        (oc_clr[gi]),
                .q          (oc_flag[gi])
            );
        end
    endgenerate
    // fault latch: bus traffic never touches it, only trips and input pins
    always_comb begin
        next_main_pend = slot_a_in.trip[OC_3V3] | slot_a_in.trip[OC_12V] |
                         (main_pend & slot_a_in.main_on_in);
        next_aux_pend  = slot_a_in.trip[OC_AUX] | (aux_pend & slot_a_in.aux_enable_in);
        fault_active   = (main_pend | aux_pend) & ~slot_a_in.smi_ctrl;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            main_pend <= 1'b0;
            aux_pend  <= 1'b0;
        end else begin
            main_pend <= next_main_pend;
            aux_pend  <= next_aux_pend;
        end
    end

    assign slot_a_fault_n_out = 1'b0;
    assign slot_a_fault_n_oe  = fault_active;
    // interrupt held low while any overcurrent flag stands
    assign alert_n_out = 1'b0;
    assign alert_n_oe  = |oc_flag;
    // read views; reserved bits read zero
    always_comb begin
        ctrl_b_rd                   = 8'h00;
        ctrl_b_rd[B_AUX_EN_BIT]     = ctrl_b.aux_enable;
        ctrl_b_rd[B_MAIN_EN_BIT]    = ctrl_b.main_enable;
        ctrl_b_rd[B_FORCE_GATE_BIT] = ctrl_b.force_gate;
        ctrl_b_rd[B_MAIN_GOOD_BIT]  = slot_b_in.main_good;
        ctrl_b_rd[B_AUX_GOOD_BIT]   = slot_b_in.aux_good;
        stat_a_rd                   = SLOT_A_STAT_RST;
        stat_a_rd[A_3V3_OC_BIT]     = oc_flag[OC_3V3];
        stat_a_rd[A_12V_OC_BIT]     = oc_flag[OC_12V];
        stat_a_rd[A_AUX_OC_BIT]     = oc_flag[OC_AUX];
        stat_a_rd[A_AUX_STATE_BIT]  = slot_a_in.aux_state;
        stat_a_rd[A_MAIN_STATE_BIT] = slot_a_in.main_state;
        stat_a_rd[A_FAULT_BIT]      = fault_active;
        unique case (cmd_ptr)
            CMD_SLOT_B_CTRL: rd_data = ctrl_b_rd;
            CMD_SLOT_A_STAT: rd_data = stat_a_rd;
            default:         rd_data = 8'h00;
        endcase
    end

endmodule // hpc_slot_regs

// ---- hpc_slot_regs_checker.sv ----
// port assertions for the hot-plug slot register bank
`timescale 1ns/100ps
module hpc_slot_regs_checker
    import hpc_pkg::*;
(
    input wire logic           core_clk,               // system clock
    input wire logic           rst_b,                  // async reset, active low
    input wire logic           alert_n_oe,             // interrupt pulled low
    input wire hpc_slot_b_in_s slot_b_in,              // slot B sense inputs
    input wire hpc_slot_a_in_s slot_a_in,              // slot A sense inputs
    input wire logic           slot_b_aux_enable,      // slot B aux switch
    input wire logic           slot_b_main_enable,     // slot B main switch
    input wire logic           slot_b_power_good_n_oe, // power-good pulled low
    input wire logic           slot_a_fault_n_oe       // fault pulled low
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // the past terms skip the two clocks of the reset synchroniser
    sequence s_main_trip;
        $past(rst_b, 2) && (slot_a_in.trip[OC_12V] || slot_a_in.trip[OC_3V3])
            ##1 !slot_a_in.smi_ctrl;
    endsequence
    sequence s_aux_trip;
        $past(rst_b, 2) && slot_a_in.trip[OC_AUX] ##1 !slot_a_in.smi_ctrl;
    endsequence

    property p_reset_off;
        $rose(rst_b) |-> !slot_b_aux_enable && !slot_b_main_enable && !alert_n_oe
            && !slot_a_fault_n_oe;
    endproperty
    property p_pg_and;
        $past(rst_b, 2) && slot_b_in.force_on_n
            |-> slot_b_power_good_n_oe == (slot_b_in.aux_good && slot_b_in.main_good);
    endproperty
    property p_pg_bad;
        !(slot_b_in.aux_good && slot_b_in.main_good) |-> !slot_b_power_good_n_oe;
    endproperty
    property p_alert_set;
        $past(rst_b, 2) && (|slot_a_in.trip) |=> alert_n_oe;
    endproperty
    property p_fault_main;
        s_main_trip |-> slot_a_fault_n_oe;
    endproperty
    property p_fault_aux;
        s_aux_trip |-> slot_a_fault_n_oe;
    endproperty
    property p_fault_hold;
        slot_a_fault_n_oe && slot_a_in.main_on_in && slot_a_in.aux_enable_in
            ##1 !slot_a_in.smi_ctrl |-> slot_a_fault_n_oe;
    endproperty
    property p_smi_mask;
        slot_a_in.smi_ctrl |-> !slot_a_fault_n_oe;
    endproperty
    property p_fault_quiet;
        !slot_a_fault_n_oe && !slot_a_in.smi_ctrl && !(|slot_a_in.trip) |=> !slot_a_fault_n_oe;
    endproperty

    a_reset_off: assert property (p_reset_off) else $error("outputs active after reset");
    a_pg_and: assert property (p_pg_and) else $error("power-good not and of goods");
    a_pg_bad: assert property (p_pg_bad) else $error("power-good with a bad supply");
    a_alert_set: assert property (p_alert_set) else $error("trip did not raise alert");
    a_fault_main: assert property (p_fault_main) else $error("main trip left no fault");
    a_fault_aux: assert property (p_fault_aux) else $error("aux trip left no fault");
    a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early");
    a_smi_mask: assert property (p_smi_mask) else $error("fault under smi control");
    a_fault_quiet: assert property (p_fault_quiet) else $error("fault rose unprompted");
endmodule // hpc_slot_regs_checker

bind hpc_slot_regs hpc_slot_regs_checker chk_u (
    .core_clk(core_clk), .rst_b(rst_b), .alert_n_oe(alert_n_oe), .slot_b_in(slot_b_in),
    .slot_a_in(slot_a_in), .slot_b_aux_enable(slot_b_aux_enable),
    .slot_b_main_enable(slot_b_main_enable),
    .slot_b_power_good_n_oe(slot_b_power_good_n_oe), .slot_a_fault_n_oe(slot_a_fault_n_oe)
);

// ---- hpc_slot_regs_tb.sv ----
// self-checking bench of the slot register bank with a reference model
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
module hpc_slot_regs_tb;
    import hpc_pkg::*;
    logic           core_clk = 1'b0;
    logic           rst_b, scl, sda_low, sda_out, sda_oe, al_out, al_oe;
    logic           bae, bme, pg_out, pg_oe, fa_out, fa_oe, ok, fm, fa;
    logic [2:0]     strap;
    logic [6:0]     adr;
    logic [7:0]     q;
    logic [31:0]    r;
    hpc_slot_b_in_s bi;
    hpc_slot_a_in_s ai;
    wire            sda;
    int             n_mismatch, n_tests, cyc, ctrl_m, flg;

    // open-drain data line with a pull-up
    assign sda = !(sda_low || (sda_oe && !sda_out));

    hpc_slot_regs dut_u (.core_clk(core_clk), .rst_b(rst_b), .smb_scl(scl), .smb_sda_in(sda),
        .smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .alert_n_out(al_out), .alert_n_oe(al_oe),
        .addr_strap_2(strap[2]), .addr_strap_1(strap[1]), .addr_strap_0(strap[0]),
        .slot_b_in(bi), .slot_a_in(ai), .slot_b_aux_enable(bae), .slot_b_main_enable(bme),
        .slot_b_power_good_n_out(pg_out), .slot_b_power_good_n_oe(pg_oe),
        .slot_a_fault_n_out(fa_out), .slot_a_fault_n_oe(fa_oe));
    hpc_smb_host host_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask

    function automatic logic [7:0] b_exp();
        return {bi.aux_good, bi.main_good, 3'h0, ctrl_m[2:0]};
    endfunction
    function automatic logic [7:0] a_exp();
        return {(fm | fa) & !ai.smi_ctrl, ai.main_state, ai.aux_state, flg[2], 1'b0, flg[1],
                1'b0, flg[0]};
    endfunction

    task automatic pins();
        `CHK("aux_en", ctrl_m[0], bae)
        `CHK("main_en", ctrl_m[1], bme)
        `CHK("pgood", bi.aux_good & bi.main_good & !(!bi.force_on_n & !ctrl_m[2]), pg_oe)
        `CHK("fault", (fm | fa) & !ai.smi_ctrl, fa_oe)
        `CHK("alert", flg != 0, al_oe)
        `CHK("od_out", 3'h0, {al_out, pg_out, fa_out})
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host_u.op(adr, 1, c, 8'h00, q, ok);
        `CHK("ack", 1'b1, ok)
        `CHK("read", e, q)
    endtask

    task automatic wst(input logic [7:0] d);
        host_u.op(adr, 0, CMD_SLOT_A_STAT, d, q, ok);
        for (int k = 0; k < 3; k++) if (d[2*k]) flg[k] = 0;
        r = $urandom;
        ai.main_state = r[0];
        ai.aux_state = r[1];
        tick(2);
        pins();
        rd(CMD_SLOT_A_STAT, a_exp());
    endtask

    task automatic trip(input int m);
        ai.trip = m[2:0];
        tick(1);
        ai.trip = 3'h0;
        flg |= m;
        fm |= (m & 3) != 0;
        fa |= m[2];
        tick(2);
        pins();
    endtask

    task automatic drop(input logic mo, input logic ae);
        ai.main_on_in = mo;
        ai.aux_enable_in = ae;
        tick(2);
        if (!mo) fm = 0;
        if (!ae) fa = 0;
        pins();
    endtask

    initial begin
        void'($urandom(32'hacc8));
        rst_b = 1'b0;
        r = $urandom;
        strap = r[2:0];
        adr = {SMB_ADDR_HIGH, strap};
        bi = '0;
        ai = '0;
        ai.main_on_in = 1'b1;
        ai.aux_enable_in = 1'b1;
        fm = 1'b0;
        fa = 1'b0;
        tick(10);
        rst_b = 1'b1;
        tick(6);
        pins();
        rd(CMD_SLOT_B_CTRL, 8'h00);
        rd(CMD_SLOT_A_STAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            bi = (i < 4) ? {2'b11, i[0]} : r[10:8];
            if (i < 4) r[2] = i[1];
            host_u.op(adr, 0, CMD_SLOT_B_CTRL, r[7:0], q, ok);
            `CHK("wack", 1'b1, ok)
            ctrl_m = r[2:0];
            tick(2);
            pins();
            rd(CMD_SLOT_B_CTRL, b_exp());
        end
        host_u.op(adr, 2, 8'h00, 8'h00, q, ok);
        `CHK("recv", b_exp(), q)
        host_u.op(adr ^ 7'h01, 0, CMD_SLOT_B_CTRL, 8'h00, q, ok);
        `CHK("foreign", 1'b0, ok)
        rd(8'h07, 8'h00);
        pins();
        trip(2);
        trip(4);
        trip(1);
        wst(8'hea);
        wst(8'h04);
        wst(8'h11);
        drop(1'b1, 1'b0);
        drop(1'b0, 1'b0);
        drop(1'b1, 1'b1);
        trip(4);
        drop(1'b0, 1'b1);
        drop(1'b0, 1'b0);
        drop(1'b1, 1'b1);
        trip(2);
        ai.smi_ctrl = 1'b1;
        tick(2);
        pins();
        rd(CMD_SLOT_A_STAT, a_exp());
        ai.smi_ctrl = 1'b0;
        drop(1'b0, 1'b1);
        ai.main_state = 1'b0;
        ai.aux_state = 1'b0;
        rst_b = 1'b0;
        tick(3);
        rst_b = 1'b1;
        tick(6);
        ctrl_m = 0;
        flg = 0;
        fm = 1'b0;
        pins();
        rd(CMD_SLOT_B_CTRL, b_exp());
        rd(CMD_SLOT_A_STAT, 8'h00);
        finish_test();
    end
endmodule // hpc_slot_regs_tb

// ---- hpc_smb_host.sv ----
// smbus host model: drives the bus clock and pulls data low
`timescale 1ns/100ps
module hpc_smb_host (
    input  wire logic core_clk, // system clock
    input  wire logic sda,      // resolved data level
    output logic      scl,      // bus clock, high when idle
    output logic      sda_low   // pull data low
);
    // half bit; the device needs four clocks per level at least
    localparam int H = 6;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask

    task automatic bitx(input logic b, output logic r);
        w(2);
        sda_low = !b;
        w(H - 2);
        scl = 1'b1;
        w(H - 1);
        r = sda;
        w(1);
        scl = 1'b0;
    endtask

    // start or repeated start, else stop with the clock left high
    task automatic cond(input logic stop);
        w(2);
        sda_low = stop;
        w(H);
        scl = 1'b1;
        w(H);
        sda_low = !stop;
        w(H);
        if (!stop) scl = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(b9, r);
        ack = !r;
    endtask

    // kind 0 write byte, 1 read byte, 2 receive byte
    task automatic op(input logic [6:0] a, input int kind, input logic [7:0] cmd,
                      input logic [7:0] dat, output logic [7:0] q, output logic ok);
        logic k1, k2, k3;
        cond(1'b0);
        xfer({a, kind == 2}, 1'b1, q, k1);
        k2 = 1'b1;
        if (kind != 2) xfer(cmd, 1'b1, q, k2);
        if (kind == 1) begin
            cond(1'b0);
            xfer({a, 1'b1}, 1'b1, q, k3);
            k2 &= k3;
        end
        k3 = 1'b1;
        if (kind == 0) xfer(dat, 1'b1, q, k3);
        else xfer(8'hff, 1'b1, q, ok);
        ok = k1 && k2 && k3;
        cond(1'b1);
    endtask
endmodule // hpc_smb_host

// ---- hpc_sticky_flag.sv ----
// one sticky overcurrent flag, set by a trip and cleared by software
`timescale 1ns/100ps
module hpc_sticky_flag
    import hpc_pkg::*;
(
    input  wire logic core_clk,     // system clock
    input  wire logic rst_sync_b,   // synchronised reset, active low
    input  wire logic set,          // breaker trip
    input  wire logic clr,          // write-one-to-clear
    output logic      q             // flag value
);

    logic next_q;

    always_comb begin
        next_q = set | (q & ~clr);
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

endmodule // hpc_sticky_flag
